// [src/mac_consts.svh]
// Offsets, field positions, reset values, keys and timing figures of the auxiliary config registers.
`ifndef MAC_CONSTS_SVH
`define MAC_CONSTS_SVH
`define MAC_ADDR_W 6
`define MAC_DATA_W 24
`define MAC_OFS_PHASE_TRIM 6'h05
`define MAC_OFS_SERIAL 6'h07
`define MAC_OFS_PULSE_DUR 6'h08
`define MAC_OFS_PULSE_SRC 6'h09
`define MAC_OFS_PULSE_RATE 6'h1c
`define MAC_OFS_LOCKS 6'h22
`define MAC_OFS_PHASE_ORDER 6'h30
`define MAC_RST_PHASE_TRIM 24'h000000
`define MAC_RST_SERIAL 24'h02004d
`define MAC_RST_PULSE_DUR 24'h000001
`define MAC_RST_PULSE_SRC 24'h000000
`define MAC_RST_PULSE_RATE 24'h800000
`define MAC_RST_LOCKS 24'h000000
`define MAC_MSK_PHASE_TRIM 24'hf3ffff
`define MAC_MSK_SERIAL 24'h06ffff
`define MAC_MSK_PULSE_DUR 24'h0fffff
`define MAC_MSK_PULSE_SRC 24'h000fff
`define MAC_MSK_PULSE_RATE 24'hffffff
`define MAC_MSK_LOCKS 24'h001f1f
`define MAC_CDP2_HI 23
`define MAC_CDP2_LO 22
`define MAC_CDP1_HI 21
`define MAC_CDP1_LO 20
`define MAC_FDP2_HI 17
`define MAC_FDP2_LO 9
`define MAC_FDP1_HI 8
`define MAC_FDP1_LO 0
`define MAC_PULLUP_OFF_BIT 18
`define MAC_CSUM_OFF_BIT 17
`define MAC_BAUD_HI 15
`define MAC_BAUD_LO 0
`define MAC_RANGE_HI 19
`define MAC_RANGE_LO 16
`define MAC_PDV_HI 15
`define MAC_PDV_LO 0
`define MAC_RANGE_MAX 4'h9
`define MAC_SRC_W 4
`define MAC_SRC_MAX 4'h8
`define MAC_ENG_KEY_HI 12
`define MAC_ENG_KEY_LO 8
`define MAC_HOST_KEY_HI 4
`define MAC_HOST_KEY_LO 0
`define MAC_KEY_LOCK 5'h16
`define MAC_KEY_UNLOCK 5'h09
`define MAC_PSD_DONE_BIT 23
`define MAC_PSD_CNT_HI 22
`define MAC_PSD_CNT_LO 16
`define MAC_PSD_DIR_BIT 5
`define MAC_PSD_CODE_HI 4
`define MAC_PSD_CODE_LO 0
`define MAC_PSD_START 5'h16
`define MAC_PSD_CNT_MAX 7'h7f
`define MAC_CLK_HZ 10000000
`define MAC_PULSE_BASE_NS 250000
`define MAC_NS_PER_S 1000000000
`define MAC_PDV_STEPS_PER_S 64000
`define MAC_DUR_W 24
`endif

// [src/mac_pkg.sv]
// Types shared by the auxiliary config register block.
package mac_pkg;
  typedef enum logic [1:0] {
    MAC_CO_NONE,
    MAC_CO_CUR_ONE,
    MAC_CO_VOLT_ONE,
    MAC_CO_VOLT_TWO
  } mac_coarse_type;
  typedef enum {
    MAC_PS_IDLE,
    MAC_PS_COUNT
  } mac_psd_state_type;
endpackage : mac_pkg

// [src/mac_pulse_gen.sv]
// Energy pulse stretcher: holds its output high for a programmed number of cycles.
`timescale 1ns/1ps
`include "mac_consts.svh"
module mac_pulse_gen (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  mac_pulse_if.gen pif
);
  logic [`MAC_DUR_W-1:0] left_ff;
  logic [`MAC_DUR_W-1:0] nxt_left;
  logic pulse_ff;
  logic start;

  // A trigger while a pulse runs is dropped, so pulses never merge.
  assign start = pif.enable && pif.trigger && (left_ff == '0);
  assign nxt_left = !pif.enable ? '0 : start ? pif.duration : (left_ff != '0) ? left_ff - 1'b1 : '0;

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      left_ff <= '0;
      pulse_ff <= 1'b0;
    end else begin
      left_ff <= nxt_left;
      pulse_ff <= (nxt_left != '0);
    end
  end

  assign pif.pulse = pulse_ff;
endmodule : mac_pulse_gen

// [src/mac_pulse_if.sv]
// Link between the register block and one energy pulse stretcher.
`timescale 1ns/1ps
`include "mac_consts.svh"
interface mac_pulse_if;
  logic enable;
  logic trigger;
  logic [`MAC_DUR_W-1:0] duration;
  logic pulse;
  modport ctrl (output enable, output trigger, output duration, input pulse);
  modport gen (input enable, input trigger, input duration, output pulse);
endinterface : mac_pulse_if

// [src/mac_regs.sv]
// Auxiliary configuration registers: phase trim, serial setup, pulse setup, locks, phase order detect.
`timescale 1ns/1ps
`include "mac_consts.svh"
module mac_regs #(
  parameter int CLK_HZ = `MAC_CLK_HZ,
  parameter int NGEN = 3
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_host_wr,
  input wire logic i_host_rd,
  input wire logic [`MAC_ADDR_W-1:0] i_host_addr,
  input wire logic [`MAC_DATA_W-1:0] i_host_wdata,
  output logic [`MAC_DATA_W-1:0] o_host_rdata,
  output logic o_host_wr_rejected,
  input wire logic i_eng_wr,
  input wire logic [`MAC_ADDR_W-1:0] i_eng_addr,
  input wire logic [`MAC_DATA_W-1:0] i_eng_wdata,
  output logic o_eng_wr_rejected,
  input wire logic i_word_tick,
  input wire logic i_volt_negative,
  input wire logic [NGEN-1:0] i_pulse_gen_enable,
  input wire logic [NGEN-1:0] i_energy_tick,
  output logic [NGEN-1:0] o_energy_pulse,
  output logic [NGEN*`MAC_SRC_W-1:0] o_pulse_source_field,
  output logic [1:0] o_coarse_delay_pair_one,
  output logic [1:0] o_coarse_delay_pair_two,
  output logic [1:0] o_cur_delay_words,
  output logic [3:0] o_volt_delay_words,
  output logic [8:0] o_fine_delay_pair_one,
  output logic [8:0] o_fine_delay_pair_two,
  output logic o_rx_pullup_enable,
  output logic o_rx_checksum_enable,
  output logic [15:0] o_baud_divisor,
  output logic [3:0] o_pulse_range_select,
  output logic o_pulse_range_valid,
  output logic [`MAC_DATA_W-1:0] o_pulse_fullscale_rate,
  output logic o_engine_locked,
  output logic o_host_locked
);
  localparam int BASE_CYC = (`MAC_PULSE_BASE_NS / 1000) * (CLK_HZ / 1000000);
  localparam int STEP_NUM = CLK_HZ / 1000;
  localparam int STEP_DEN = `MAC_PDV_STEPS_PER_S / 1000;

  ////////////////////////////////////////////////////////////////////////////
  logic [`MAC_DATA_W-1:0] phase_delay_trim_ff;
  logic [`MAC_DATA_W-1:0] serial_port_setup_ff;
  logic [`MAC_DATA_W-1:0] pulse_duration_range_ff;
  logic [`MAC_DATA_W-1:0] pulse_source_select_ff;
  logic [`MAC_DATA_W-1:0] pulse_fullscale_rate_ff;
  logic [`MAC_DATA_W-1:0] write_protect_keys_ff;
  logic engine_locked_ff;
  logic host_locked_ff;
  logic seq_dir_ff;
  logic [4:0] seq_code_ff;
  logic [6:0] sequence_sample_count_ff;
  logic seq_done_ff;
  logic prev_negative_ff;
  logic prev_valid_ff;
  mac_pkg::mac_psd_state_type seq_state_ff;
  logic [`MAC_DATA_W-1:0] rdata_ff;
  logic host_rej_ff;
  logic eng_rej_ff;
  logic rx_pu_en_ff;
  logic rx_cs_en_ff;
  logic rng_ok_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Write qualification. Register 0x22 stays writable from the host so the lock can be lifted.
  logic host_to_lock_reg;
  logic host_ok;
  logic eng_ok;
  logic host_mapped;
  assign host_to_lock_reg = (i_host_addr == `MAC_OFS_LOCKS);
  assign host_ok = i_host_wr && (!host_locked_ff || host_to_lock_reg);
  assign eng_ok = i_eng_wr && !engine_locked_ff && (i_eng_addr != `MAC_OFS_LOCKS);

  logic wr_trim;
  logic wr_serial;
  logic wr_dur;
  logic wr_src;
  logic wr_rate;
  logic wr_locks;
  logic wr_psd;
  logic h_trim, h_serial, h_dur, h_src, h_rate, h_psd;
  logic [`MAC_DATA_W-1:0] psd_wd;
  assign h_trim = host_ok && i_host_addr == `MAC_OFS_PHASE_TRIM;
  assign h_serial = host_ok && i_host_addr == `MAC_OFS_SERIAL;
  assign h_dur = host_ok && i_host_addr == `MAC_OFS_PULSE_DUR;
  assign h_src = host_ok && i_host_addr == `MAC_OFS_PULSE_SRC;
  assign h_rate = host_ok && i_host_addr == `MAC_OFS_PULSE_RATE;
  assign h_psd = host_ok && i_host_addr == `MAC_OFS_PHASE_ORDER;
  assign wr_trim = h_trim || (eng_ok && i_eng_addr == `MAC_OFS_PHASE_TRIM);
  assign wr_serial = h_serial || (eng_ok && i_eng_addr == `MAC_OFS_SERIAL);
  assign wr_dur = h_dur || (eng_ok && i_eng_addr == `MAC_OFS_PULSE_DUR);
  assign wr_src = h_src || (eng_ok && i_eng_addr == `MAC_OFS_PULSE_SRC);
  assign wr_rate = h_rate || (eng_ok && i_eng_addr == `MAC_OFS_PULSE_RATE);
  assign wr_locks = host_ok && host_to_lock_reg;
  assign wr_psd = h_psd || (eng_ok && i_eng_addr == `MAC_OFS_PHASE_ORDER);
  // Host wins a shared target; distinct targets both land.
  assign psd_wd = h_psd ? i_host_wdata : i_eng_wdata;

  logic [`MAC_DATA_W-1:0] nxt_trim;
  logic [`MAC_DATA_W-1:0] nxt_serial;
  logic [`MAC_DATA_W-1:0] nxt_dur;
  logic [`MAC_DATA_W-1:0] nxt_src;
  logic [`MAC_DATA_W-1:0] nxt_rate;
  logic [`MAC_DATA_W-1:0] nxt_locks;
  assign nxt_trim = wr_trim ? ((h_trim ? i_host_wdata : i_eng_wdata) & `MAC_MSK_PHASE_TRIM)
    : phase_delay_trim_ff;
  assign nxt_serial = wr_serial ? ((h_serial ? i_host_wdata : i_eng_wdata) & `MAC_MSK_SERIAL)
    : serial_port_setup_ff;
  assign nxt_dur = wr_dur ? ((h_dur ? i_host_wdata : i_eng_wdata) & `MAC_MSK_PULSE_DUR) : pulse_duration_range_ff;
  assign nxt_src = wr_src ? ((h_src ? i_host_wdata : i_eng_wdata) & `MAC_MSK_PULSE_SRC) : pulse_source_select_ff;
  assign nxt_rate = wr_rate ? ((h_rate ? i_host_wdata : i_eng_wdata) & `MAC_MSK_PULSE_RATE)
    : pulse_fullscale_rate_ff;
  assign nxt_locks = wr_locks ? (i_host_wdata & `MAC_MSK_LOCKS) : write_protect_keys_ff;

  logic [4:0] eng_key;
  logic [4:0] host_key;
  logic nxt_eng_lock;
  logic nxt_host_lock;
  assign eng_key = i_host_wdata[`MAC_ENG_KEY_HI:`MAC_ENG_KEY_LO];
  assign host_key = i_host_wdata[`MAC_HOST_KEY_HI:`MAC_HOST_KEY_LO];
  // Other key values are stored but leave the protection state alone.
  assign nxt_eng_lock = (wr_locks && eng_key == `MAC_KEY_LOCK) ? 1'b1
    : (wr_locks && eng_key == `MAC_KEY_UNLOCK) ? 1'b0 : engine_locked_ff;
  assign nxt_host_lock = (wr_locks && host_key == `MAC_KEY_LOCK) ? 1'b1
    : (wr_locks && host_key == `MAC_KEY_UNLOCK) ? 1'b0 : host_locked_ff;

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      phase_delay_trim_ff <= `MAC_RST_PHASE_TRIM;
      serial_port_setup_ff <= `MAC_RST_SERIAL;
      pulse_duration_range_ff <= `MAC_RST_PULSE_DUR;
      pulse_source_select_ff <= `MAC_RST_PULSE_SRC;
      pulse_fullscale_rate_ff <= `MAC_RST_PULSE_RATE;
      write_protect_keys_ff <= `MAC_RST_LOCKS;
      engine_locked_ff <= 1'b0;
      host_locked_ff <= 1'b0;
      rx_pu_en_ff <= 1'b1;
      rx_cs_en_ff <= 1'b0;
      rng_ok_ff <= 1'b1;
    end else begin
      phase_delay_trim_ff <= nxt_trim;
      serial_port_setup_ff <= nxt_serial;
      pulse_duration_range_ff <= nxt_dur;
      pulse_source_select_ff <= nxt_src;
      pulse_fullscale_rate_ff <= nxt_rate;
      write_protect_keys_ff <= nxt_locks;
      engine_locked_ff <= nxt_eng_lock;
      host_locked_ff <= nxt_host_lock;
      rx_pu_en_ff <= !nxt_serial[`MAC_PULLUP_OFF_BIT];
      rx_cs_en_ff <= !nxt_serial[`MAC_CSUM_OFF_BIT];
      rng_ok_ff <= (nxt_dur[`MAC_RANGE_HI:`MAC_RANGE_LO] <= `MAC_RANGE_MAX);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase order detection. The sign sample comes from the same clock, so no synchroniser.
  logic start_key;
  logic rise_cross;
  logic fall_cross;
  logic stop_cross;
  logic [6:0] nxt_count;
  logic nxt_done;
  logic nxt_dir;
  logic [4:0] nxt_code;
  mac_pkg::mac_psd_state_type nxt_state;
  assign start_key = wr_psd && (psd_wd[`MAC_PSD_CODE_HI:`MAC_PSD_CODE_LO] == `MAC_PSD_START);
  assign nxt_dir = wr_psd ? psd_wd[`MAC_PSD_DIR_BIT] : seq_dir_ff;
  assign nxt_code = wr_psd ? psd_wd[`MAC_PSD_CODE_HI:`MAC_PSD_CODE_LO] : seq_code_ff;
  assign rise_cross = prev_valid_ff && prev_negative_ff && !i_volt_negative;
  assign fall_cross = prev_valid_ff && !prev_negative_ff && i_volt_negative;
  assign stop_cross = i_word_tick && (seq_dir_ff ? fall_cross : rise_cross);

  always_comb begin
    nxt_state = seq_state_ff;
    nxt_count = sequence_sample_count_ff;
    nxt_done = seq_done_ff;
    case (seq_state_ff)
      mac_pkg::MAC_PS_IDLE: begin
        if (start_key) begin
          nxt_state = mac_pkg::MAC_PS_COUNT;
          nxt_count = '0;
          nxt_done = 1'b0;
        end
      end
      mac_pkg::MAC_PS_COUNT: begin
        if (start_key) begin
          nxt_count = '0;
        end else if (stop_cross) begin
          nxt_state = mac_pkg::MAC_PS_IDLE;
          nxt_done = 1'b1;
        end else if (i_word_tick && sequence_sample_count_ff != `MAC_PSD_CNT_MAX) begin
          nxt_count = sequence_sample_count_ff + 7'h01;
        end
      end
      default: begin
        nxt_state = mac_pkg::MAC_PS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      seq_state_ff <= mac_pkg::MAC_PS_IDLE;
      sequence_sample_count_ff <= '0;
      seq_done_ff <= 1'b0;
      seq_dir_ff <= 1'b0;
      seq_code_ff <= '0;
      prev_negative_ff <= 1'b0;
      prev_valid_ff <= 1'b0;
    end else begin
      seq_state_ff <= nxt_state;
      sequence_sample_count_ff <= nxt_count;
      seq_done_ff <= nxt_done;
      seq_dir_ff <= nxt_dir;
      seq_code_ff <= nxt_code;
      if (i_word_tick) begin
        prev_negative_ff <= i_volt_negative;
        prev_valid_ff <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path and write refusal answers, one cycle after the strobe.
  logic [`MAC_DATA_W-1:0] psd_word;
  logic [`MAC_DATA_W-1:0] rd_mux;
  assign psd_word = {seq_done_ff, sequence_sample_count_ff, 10'h000, seq_dir_ff, seq_code_ff};
  assign host_mapped = (i_host_addr == `MAC_OFS_PHASE_TRIM) || (i_host_addr == `MAC_OFS_SERIAL)
    || (i_host_addr == `MAC_OFS_PULSE_DUR) || (i_host_addr == `MAC_OFS_PULSE_SRC)
    || (i_host_addr == `MAC_OFS_PULSE_RATE) || host_to_lock_reg || (i_host_addr == `MAC_OFS_PHASE_ORDER);

  always_comb begin
    if (i_host_addr == `MAC_OFS_PHASE_TRIM) begin
      rd_mux = phase_delay_trim_ff;
    end else if (i_host_addr == `MAC_OFS_SERIAL) begin
      rd_mux = serial_port_setup_ff;
    end else if (i_host_addr == `MAC_OFS_PULSE_DUR) begin
      rd_mux = pulse_duration_range_ff;
    end else if (i_host_addr == `MAC_OFS_PULSE_SRC) begin
      rd_mux = pulse_source_select_ff;
    end else if (i_host_addr == `MAC_OFS_PULSE_RATE) begin
      rd_mux = pulse_fullscale_rate_ff;
    end else if (host_to_lock_reg) begin
      rd_mux = write_protect_keys_ff;
    end else if (i_host_addr == `MAC_OFS_PHASE_ORDER) begin
      rd_mux = psd_word;
    end else begin
      rd_mux = '0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_ff <= '0;
      host_rej_ff <= 1'b0;
      eng_rej_ff <= 1'b0;
    end else begin
      if (i_host_rd) begin
        rdata_ff <= rd_mux;
      end
      host_rej_ff <= i_host_wr && host_mapped && !host_ok;
      eng_rej_ff <= i_eng_wr && !eng_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded settings, registered so every output leaves a flip-flop.
  logic [1:0] co1;
  logic [1:0] co2;
  logic [`MAC_DATA_W-1:0] dur_cyc;
  logic [15:0] pdv;
  assign co1 = phase_delay_trim_ff[`MAC_CDP1_HI:`MAC_CDP1_LO];
  assign co2 = phase_delay_trim_ff[`MAC_CDP2_HI:`MAC_CDP2_LO];
  assign pdv = pulse_duration_range_ff[`MAC_PDV_HI:`MAC_PDV_LO];
  // Fractional cycles of the summed steps are dropped; at 10 MHz one step is 156.25 cycles.
  assign dur_cyc = `MAC_DUR_W'(BASE_CYC) + `MAC_DUR_W'((64'(pdv) * 64'(STEP_NUM)) / 64'(STEP_DEN));

  logic [NGEN-1:0] src_ok;
  genvar g;
  generate
    for (g = 0; g < NGEN; g = g + 1) begin : gen_pulse
      mac_pulse_if pif ();
      assign src_ok[g] = pulse_source_select_ff[g*`MAC_SRC_W +: `MAC_SRC_W] <= `MAC_SRC_MAX;
      assign pif.enable = i_pulse_gen_enable[g] && src_ok[g];
      assign pif.trigger = i_energy_tick[g];
      assign pif.duration = dur_cyc;
      assign o_energy_pulse[g] = pif.pulse;
      mac_pulse_gen u_gen (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .pif(pif.gen)
      );
    end
  endgenerate

  logic [1:0] cur_dly_ff;
  logic [3:0] volt_dly_ff;
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cur_dly_ff <= '0;
      volt_dly_ff <= '0;
    end else begin
      cur_dly_ff <= {co2 == mac_pkg::MAC_CO_CUR_ONE, co1 == mac_pkg::MAC_CO_CUR_ONE};
      volt_dly_ff <= {co2 == mac_pkg::MAC_CO_VOLT_TWO, co2 == mac_pkg::MAC_CO_VOLT_ONE,
                      co1 == mac_pkg::MAC_CO_VOLT_TWO, co1 == mac_pkg::MAC_CO_VOLT_ONE};
    end
  end

  assign o_host_rdata = rdata_ff;
  assign o_host_wr_rejected = host_rej_ff;
  assign o_eng_wr_rejected = eng_rej_ff;
  assign o_pulse_source_field = pulse_source_select_ff[NGEN*`MAC_SRC_W-1:0];
  assign o_coarse_delay_pair_one = phase_delay_trim_ff[`MAC_CDP1_HI:`MAC_CDP1_LO];
  assign o_coarse_delay_pair_two = phase_delay_trim_ff[`MAC_CDP2_HI:`MAC_CDP2_LO];
  assign o_cur_delay_words = cur_dly_ff;
  assign o_volt_delay_words = volt_dly_ff;
  assign o_fine_delay_pair_one = phase_delay_trim_ff[`MAC_FDP1_HI:`MAC_FDP1_LO];
  assign o_fine_delay_pair_two = phase_delay_trim_ff[`MAC_FDP2_HI:`MAC_FDP2_LO];
  assign o_rx_pullup_enable = rx_pu_en_ff;
  assign o_rx_checksum_enable = rx_cs_en_ff;
  assign o_baud_divisor = serial_port_setup_ff[`MAC_BAUD_HI:`MAC_BAUD_LO];
  assign o_pulse_range_select = pulse_duration_range_ff[`MAC_RANGE_HI:`MAC_RANGE_LO];
  assign o_pulse_range_valid = rng_ok_ff;
  assign o_pulse_fullscale_rate = pulse_fullscale_rate_ff;
  assign o_engine_locked = engine_locked_ff;
  assign o_host_locked = host_locked_ff;
endmodule : mac_regs

// [testbench/mac_host_model.sv]
// Host processor model on the register port: word writes, word reads and setup helpers.
`timescale 1ns/1ps
`include "mac_consts.svh"
module mac_host_model #(
  parameter int CLK_HZ = `MAC_CLK_HZ
) (
  input wire logic i_core_clk,
  output logic o_wr,
  output logic o_rd,
  output logic [`MAC_ADDR_W-1:0] o_addr,
  output logic [`MAC_DATA_W-1:0] o_wdata,
  input wire logic [`MAC_DATA_W-1:0] i_rdata,
  input wire logic i_rejected
);
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 6'h00;
    o_wdata = 24'h000000;
  end
  ////////////////////////////////////////////////////////////
  // The divisor truncates, so the real bit rate sits a little below the request.
  function automatic logic [15:0] baud_for(input int rate);
    return 16'(longint'(rate) * 524288 / CLK_HZ);
  endfunction : baud_for
  // Released lines carry the inverse so a stale value can never pass for a request.
  task automatic wr_reg(input logic [5:0] a, input logic [23:0] d, output logic rej);
    @(posedge i_core_clk);
    o_wr <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_core_clk);
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
    #1 rej = i_rejected;
  endtask : wr_reg
  task automatic rd_reg(input logic [5:0] a, output logic [23:0] d);
    @(posedge i_core_clk);
    o_rd <= 1'b1;
    o_addr <= a;
    @(posedge i_core_clk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    #1 d = i_rdata;
  endtask : rd_reg
  task automatic psd_start(input logic dir);
    logic r;
    wr_reg(6'h30, {18'h0, dir, 5'h16}, r);
  endtask : psd_start
endmodule : mac_host_model

// [testbench/mac_regs_props.sv]
// Concurrent checks on the ports of the auxiliary config register block.
`timescale 1ns/1ps
`include "mac_consts.svh"
module mac_regs_props #(
  parameter int NGEN = 3
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_host_wr,
  input wire logic [`MAC_ADDR_W-1:0] i_host_addr,
  input wire logic [`MAC_DATA_W-1:0] i_host_wdata,
  input wire logic o_host_wr_rejected,
  input wire logic o_host_locked,
  input wire logic o_engine_locked,
  input wire logic [1:0] o_coarse_delay_pair_one,
  input wire logic [1:0] o_cur_delay_words,
  input wire logic [3:0] o_volt_delay_words,
  input wire logic o_rx_pullup_enable,
  input wire logic o_rx_checksum_enable,
  input wire logic [15:0] o_baud_divisor,
  input wire logic [3:0] o_pulse_range_select,
  input wire logic o_pulse_range_valid,
  input wire logic [NGEN-1:0] i_pulse_gen_enable,
  input wire logic [NGEN-1:0] o_energy_pulse
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_reset_n);
  ////////////////////////////////////////////////////////////
  sequence s_serial_wr;
    i_host_wr && i_host_addr == 6'h07 && !o_host_locked;
  endsequence
  sequence s_lock_wr;
    i_host_wr && i_host_addr == 6'h22;
  endsequence
  chk_pullup_tracks_bit: assert property (s_serial_wr |=> o_rx_pullup_enable == !$past(i_host_wdata[18]))
    else $error("Pull-up enable does not follow its bit.");
  chk_csum_tracks_bit: assert property (s_serial_wr |=> o_rx_checksum_enable == !$past(i_host_wdata[17]))
    else $error("Checksum enable does not follow its bit.");
  chk_baud_divisor_stored: assert property (s_serial_wr |=> o_baud_divisor == $past(i_host_wdata[15:0]))
    else $error("Baud divisor not stored.");
  chk_locked_write_refused: assert property (i_host_wr && i_host_addr == 6'h07 && o_host_locked
    |=> o_host_wr_rejected && $stable(o_baud_divisor))
    else $error("Locked host write was not refused.");
  chk_host_lock_key: assert property (s_lock_wr ##0 i_host_wdata[4:0] == 5'h16 |=> o_host_locked)
    else $error("Host lock key ignored.");
  chk_host_unlock_key: assert property (s_lock_wr ##0 i_host_wdata[4:0] == 5'h09 |=> !o_host_locked)
    else $error("Host unlock key ignored.");
  chk_engine_lock_key: assert property (s_lock_wr ##0 i_host_wdata[12:8] == 5'h16 |=> o_engine_locked)
    else $error("Engine lock key ignored.");
  chk_range_valid_code: assert property ($stable(o_pulse_range_select)
    |-> o_pulse_range_valid == (o_pulse_range_select <= 4'h9))
    else $error("Range valid flag wrong.");
  chk_coarse_decode_map: assert property ($stable(o_coarse_delay_pair_one)
    |-> o_cur_delay_words[0] == (o_coarse_delay_pair_one == 2'h1)
    && o_volt_delay_words[1:0] == {o_coarse_delay_pair_one == 2'h3, o_coarse_delay_pair_one == 2'h2})
    else $error("Coarse delay decode wrong.");
  chk_pulse_gen_off: assert property (!i_pulse_gen_enable[0] [*2] |-> !o_energy_pulse[0])
    else $error("Disabled generator pulses.");
endmodule : mac_regs_props
bind mac_regs mac_regs_props #(.NGEN(NGEN)) i_mac_regs_props (
  .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_host_wr(i_host_wr), .i_host_addr(i_host_addr),
  .i_host_wdata(i_host_wdata), .o_host_wr_rejected(o_host_wr_rejected), .o_host_locked(o_host_locked),
  .o_engine_locked(o_engine_locked), .o_coarse_delay_pair_one(o_coarse_delay_pair_one),
  .o_cur_delay_words(o_cur_delay_words), .o_volt_delay_words(o_volt_delay_words),
  .o_rx_pullup_enable(o_rx_pullup_enable), .o_rx_checksum_enable(o_rx_checksum_enable),
  .o_baud_divisor(o_baud_divisor), .o_pulse_range_select(o_pulse_range_select),
  .o_pulse_range_valid(o_pulse_range_valid), .i_pulse_gen_enable(i_pulse_gen_enable),
  .o_energy_pulse(o_energy_pulse)
);

// [testbench/test_meter_aux_config_registers.sv]
// Self-checking bench of the auxiliary config register block.
`timescale 1ns/1ps
`include "mac_consts.svh"
module test_meter_aux_config_registers;
  logic clk, rst_n, h_wr, h_rd, h_rej, e_wr, e_rej, tick, vneg, pu, cs, rv, r, seen;
  logic [5:0] h_addr, e_addr;
  logic [23:0] h_wd, h_rdata, e_wd, v, w;
  logic [2:0] gen_en, etick, epulse;
  logic [1:0] curw;
  logic [3:0] voltw;
  int mismatches, checked, n, k;
  logic [5:0] ofs [7] = '{6'h05, 6'h07, 6'h08, 6'h09, 6'h1c, 6'h22, 6'h30};
  logic [23:0] rst [7] = '{24'h0, 24'h02004d, 24'h1, 24'h0, 24'h800000, 24'h0, 24'h0};
  logic [23:0] msk [5] = '{24'hf3ffff, 24'h06ffff, 24'h0fffff, 24'h000fff, 24'hffffff};
  mac_host_model i_mac_host_model (
    .i_core_clk(clk), .o_wr(h_wr), .o_rd(h_rd), .o_addr(h_addr), .o_wdata(h_wd),
    .i_rdata(h_rdata), .i_rejected(h_rej)
  );
  mac_regs i_mac_regs (
    .i_core_clk(clk), .i_reset_n(rst_n), .i_host_wr(h_wr), .i_host_rd(h_rd), .i_host_addr(h_addr),
    .i_host_wdata(h_wd), .o_host_rdata(h_rdata), .o_host_wr_rejected(h_rej), .i_eng_wr(e_wr),
    .i_eng_addr(e_addr), .i_eng_wdata(e_wd), .o_eng_wr_rejected(e_rej), .i_word_tick(tick),
    .i_volt_negative(vneg), .i_pulse_gen_enable(gen_en), .i_energy_tick(etick),
    .o_energy_pulse(epulse), .o_pulse_source_field(), .o_coarse_delay_pair_one(),
    .o_coarse_delay_pair_two(), .o_cur_delay_words(curw), .o_volt_delay_words(voltw),
    .o_fine_delay_pair_one(), .o_fine_delay_pair_two(), .o_rx_pullup_enable(pu),
    .o_rx_checksum_enable(cs), .o_baud_divisor(), .o_pulse_range_select(),
    .o_pulse_range_valid(rv), .o_pulse_fullscale_rate(), .o_engine_locked(), .o_host_locked()
  );
  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    checked++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask : chk
  task automatic hw(input logic [5:0] a, input logic [23:0] d);
    i_mac_host_model.wr_reg(a, d, r);
  endtask : hw
  task automatic hr(input logic [5:0] a);
    i_mac_host_model.rd_reg(a, v);
  endtask : hr
  task automatic ew(input logic [5:0] a, input logic [23:0] d);
    @(posedge clk);
    e_wr <= 1'b1;
    e_addr <= a;
    e_wd <= d;
    @(posedge clk);
    e_wr <= 1'b0;
    e_wd <= ~d;
    #1 r = e_rej;
  endtask : ew
  task automatic tk(input logic neg, input int cnt);
    repeat (cnt) begin
      @(posedge clk);
      tick <= 1'b1;
      vneg <= neg;
      @(posedge clk);
      tick <= 1'b0;
    end
  endtask : tk
  task automatic summarize;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #6000000;
    mismatches++;
    summarize();
  end
  initial begin
    rst_n = 1'b0;
    {e_wr, tick, vneg, gen_en, etick, e_addr, e_wd} = '0;
    mismatches = 0;
    checked = 0;
    void'($urandom(81457));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      hr(ofs[i]);
      chk("reset value", rst[i], v);
    end
    chk("pull-up on", 24'h1, {23'h0, pu});
    chk("checksum off", 24'h0, {23'h0, cs});
    repeat (4) begin
      for (int i = 0; i < 5; i++) begin
        w = $urandom;
        w[0] = w[0] | (i == 2);
        hw(ofs[i], w);
        hr(ofs[i]);
        chk("readback", w & msk[i], v);
      end
    end
    hw(6'h07, {5'h0, 1'b1, 1'b0, 1'b0, i_mac_host_model.baud_for(9600)});
    hr(6'h07);
    chk("serial setup", 24'h0401f7, v);
    chk("pull-up off", 24'h0, {23'h0, pu});
    chk("checksum on", 24'h1, {23'h0, cs});
    for (int c = 0; c < 4; c++) begin
      hw(6'h05, {c[1:0], c[1:0], 20'h0});
      @(posedge clk);
      #1 chk("coarse", {18'h0, c == 1, c == 1, c == 3, c == 2, c == 3, c == 2}, {18'h0, curw, voltw});
    end
    for (int q = 9; q < 11; q++) begin
      hw(6'h08, {4'h0, q[3:0], 16'h0001});
      @(posedge clk);
      #1 chk("range valid", {23'h0, q == 9}, {23'h0, rv});
    end
    hw(6'h3f, 24'hffffff);
    chk("unmapped flag", 24'h0, {23'h0, r});
    hr(6'h3f);
    chk("unmapped read", 24'h0, v);
    hw(6'h22, 24'h000016);
    hw(6'h07, 24'h0);
    chk("locked flag", 24'h1, {23'h0, r});
    hr(6'h07);
    chk("locked serial", 24'h0401f7, v);
    hw(6'h22, 24'h000009);
    hw(6'h07, 24'h02004d);
    chk("unlocked flag", 24'h0, {23'h0, r});
    ew(6'h09, 24'h000123);
    hw(6'h22, 24'h001600);
    ew(6'h09, 24'h000456);
    chk("engine refused", 24'h1, {23'h0, r});
    hr(6'h09);
    chk("engine locked", 24'h000123, v);
    hw(6'h22, 24'h000900);
    ew(6'h09, 24'h000900);
    hr(6'h09);
    chk("engine unlocked", 24'h000900, v);
    tk(1'b1, 1);
    hw(6'h30, 24'h000015);
    tk(1'b1, 3);
    tk(1'b0, 1);
    hr(6'h30);
    chk("no start", 24'h000015, v);
    for (int d = 0; d < 2; d++) begin
      tk(!d[0], 1);
      i_mac_host_model.psd_start(d[0]);
      k = $urandom_range(12, 1);
      tk(!d[0], k);
      hr(6'h30);
      chk("counting", 24'((k << 16) | (d << 5) | 24'h16), v);
      i_mac_host_model.psd_start(d[0]);
      k = $urandom_range(100, 1);
      tk(!d[0], k);
      tk(d[0], 2);
      hr(6'h30);
      chk("sequence done", 24'(24'h800000 | (k << 16) | (d << 5) | 24'h16), v);
    end
    hw(6'h08, 24'h000002);
    @(posedge clk);
    gen_en <= 3'b101;
    @(posedge clk);
    etick <= 3'b111;
    @(posedge clk);
    etick <= 3'b000;
    n = 0;
    seen = 1'b0;
    for (int i = 0; i < 4000 && (n == 0 || epulse[0] === 1'b1); i++) begin
      #1;
      if (epulse[0] === 1'b1) n++;
      seen = seen | (epulse[2:1] !== 2'b00);
      @(posedge clk);
    end
    chk("pulse length", 24'(2500 + 2 * 10000 / 64), 24'(n));
    chk("idle generators", 24'h0, {23'h0, seen});
    @(posedge clk);
    etick <= 3'b001;
    @(posedge clk);
    etick <= 3'b000;
    repeat (20) @(posedge clk);
    gen_en <= 3'b000;
    repeat (4) @(posedge clk);
    #1 chk("disable clears", 24'h0, {21'h0, epulse});
    summarize();
  end
endmodule : test_meter_aux_config_registers
